// ===== charge_level_decode.sv
// Decoder for the charge level pin: low, high or floating
`timescale 1ns/1ps
module charge_level_decode (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sink_over_window,
   input wire logic i_source_over_window,
   input wire logic i_pin_high,
   output chg_regs_pkg::level_t o_level
);
   // Pin current inside +/-2 uA asserts neither window comparator
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_level <= chg_regs_pkg::LEVEL_FLOAT;
      end else if (!i_sink_over_window && !i_source_over_window) begin
         o_level <= chg_regs_pkg::LEVEL_FLOAT; // [R04]
      end else if (i_pin_high) begin
         o_level <= chg_regs_pkg::LEVEL_HIGH; // [R05]
      end else begin
         o_level <= chg_regs_pkg::LEVEL_LOW; // [R05]
      end
   end
endmodule // charge_level_decode

// ===== chg_host_model.sv
// Host model: single-byte writes and reads on the register port
`timescale 1ns/1ps
module chg_host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rd_data,
   output logic o_wr_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wr_data
);
   initial begin
      o_wr_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr_en <= 1'b1;
      o_addr <= a;
      // Exact bit always carries its default
      o_wr_data <= (a == 8'h0b) ? {d[7:4], chg_regs_pkg::RST_EXACT, d[2:0]} : d;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      // Stale data would hide a write taken without the strobe
      o_wr_data <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      d = i_rd_data;
   endtask
endmodule // chg_host_model

// ===== chg_regs_asserts.sv
// Checker: port-level properties of the charger register block
`timescale 1ns/1ps
module chg_regs_asserts (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic [7:0] o_rd_data,
   input wire logic i_sink_over_window,
   input wire logic i_source_over_window,
   input wire logic i_pin_high,
   input wire logic i_vin_above_bat,
   input wire logic i_vin_above_uvlo,
   input wire logic o_charge_enable,
   input wire logic [1:0] o_current_mode,
   input wire logic [3:0] o_fast_charge_level_a,
   input wire logic [2:0] o_state
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic sup_ok;
   logic pin_lo;
   logic pin_hi;
   assign sup_ok = i_vin_above_bat && i_vin_above_uvlo;
   // Field override masks the pin, so only a zero field is judged
   assign pin_lo = i_sink_over_window && !i_pin_high && o_fast_charge_level_a == 4'h0;
   assign pin_hi = i_source_over_window && i_pin_high && o_fast_charge_level_a == 4'h0;
   ////////////////////////////////////////////////////////////
   sequence suspend_seen;
      (i_addr == 8'h0b) [*2] ##0 o_rd_data[0];
   endsequence
   sequence level_a_written;
      (i_wr_en && i_addr == 8'h08) ##1 !i_wr_en;
   endsequence
   ////////////////////////////////////////////////////////////
   float_stops_charge_a: assert property (
      (!i_sink_over_window && !i_source_over_window) [*4] |-> !o_charge_enable)
      else $error("charging while level pin floats");
   level_low_mode_a: assert property (pin_lo [*4] |-> o_current_mode == 2'h0)
      else $error("low pin did not select low current");
   level_high_mode_a: assert property (pin_hi [*4] |-> o_current_mode == 2'h1)
      else $error("high pin did not select high current");
   active_enable_a: assert property (
      o_charge_enable == (o_state >= 3'h3 && o_state <= 3'h5))
      else $error("charge enable disagrees with state");
   state_code_a: assert property (o_state <= 3'h5)
      else $error("undefined state code");
   supply_flag_a: assert property ((sup_ok && i_addr == 8'h09) [*3] |-> o_rd_data[0])
      else $error("supply good flag clear with good supply");
   healthy_flag_a: assert property (
      (!i_vin_above_uvlo && i_addr == 8'h0b) [*3] |-> !o_rd_data[1])
      else $error("healthy flag set below lockout");
   suspend_bit_a: assert property (suspend_seen |=> !o_charge_enable)
      else $error("charging with suspend bit set");
   timeout_latch_a: assert property (
      o_state == 3'h2 && sup_ok |=> o_state == 3'h2)
      else $error("timeout fault left with supply present");
   read_only_low_a: assert property ((i_addr == 8'h08) [*2] |-> o_rd_data[3:0] == 4'h0)
      else $error("read-only bits not zero");
   level_a_write_a: assert property (
      level_a_written |=> {o_fast_charge_level_a, 4'h0} == ($past(i_wr_data, 2) & 8'hf0))
      else $error("level field did not take written value");
endmodule // chg_regs_asserts

// ===== chg_regs_pkg.sv
// Package: register offsets, field positions, reset values and timing counts for the charger
package chg_regs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses on the serial register port)
   localparam logic [7:0] ADDR_CURRENT_PRIMARY = 8'h08;
   localparam logic [7:0] ADDR_STATUS_TIMEOUT = 8'h09;
   localparam logic [7:0] ADDR_MODE_CURRENT_ALT = 8'h0a;
   localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h0b;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int LEVEL_A_LSB = 4;
   localparam int LEVEL_B_LSB = 4;
   localparam int LINEAR_MODE_BIT = 7;
   localparam int SUPPLY_GOOD_BIT = 0;
   localparam int CHARGING_BIT = 1;
   localparam int THERMAL_BIT = 2;
   localparam int TIMER_FAULT_BIT = 3;
   localparam int BATTERY_MISSING_BIT = 4;
   localparam int TIMER_SELECT_LSB = 6;
   localparam int SUSPEND_BIT = 0;
   localparam int HEALTHY_BIT = 1;
   localparam int USB_SELECT_BIT = 2;
   localparam int EXACT_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values of writable fields
   localparam logic [3:0] RST_LEVEL_A = 4'h0;
   localparam logic [2:0] RST_LEVEL_B = 3'h0;
   localparam logic RST_LINEAR_MODE = 1'b0;
   localparam logic [1:0] RST_TIMER_SELECT = 2'h2;
   localparam logic RST_SUSPEND = 1'b0;
   localparam logic RST_USB_SELECT = 1'b0;
   localparam logic RST_EXACT = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Timeout selections and timing
   localparam logic [1:0] TIMER_60 = 2'h0;
   localparam logic [1:0] TIMER_90 = 2'h1;
   localparam logic [1:0] TIMER_120 = 2'h2;
   localparam logic [1:0] TIMER_NONE = 2'h3;
   localparam longint CLK_HZ = 40000000;
   localparam longint TICK_MS = 1;
   localparam int TICK_CYCLES = int'((CLK_HZ * TICK_MS) / 1000);
   localparam longint MIN_60 = 60;
   localparam longint MIN_90 = 90;
   localparam longint MIN_120 = 120;
   localparam int MS_PER_MIN = 60000;
   localparam int TICKS_60 = int'(MIN_60 * MS_PER_MIN / TICK_MS);
   localparam int TICKS_90 = int'(MIN_90 * MS_PER_MIN / TICK_MS);
   localparam int TICKS_120 = int'(MIN_120 * MS_PER_MIN / TICK_MS);

   // Charge level pin states as decoded from the pad's current sense
   typedef enum logic [1:0] {
      LEVEL_LOW = 2'b00,
      LEVEL_HIGH = 2'b01,
      LEVEL_FLOAT = 2'b10
   } level_t;

   typedef enum logic [2:0] {
      ST_SLEEP = 3'b000,
      ST_SUSPEND = 3'b001,
      ST_TIMEOUT_FAULT = 3'b010,
      ST_PRECONDITION = 3'b011,
      ST_FAST_CHARGE = 3'b100,
      ST_TOP_OFF = 3'b101
   } charge_state_t;

endpackage

// ===== li_charger_control_regs.sv
// Charger control and status registers with the charge state controller
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R01: Host writes exact bits with default values
// R02: Read-only bits ignore writes
// R03: Status bit 0 reports input supply good
// R04: Floating level pin suspends charging
// R05: Level pin low 90 mA, high 450 mA
// R06: Sleep, suspend, fault, precondition, fast, top-off
// R07: Restart charge 200 mV below termination
// R08: Timer select 60/90/120/none; expiry faults
// R09: Auto charge unless float, suspend, fault
// R10: Healthy needs input good and no fault
// R11: Register 0Bh bit 0 suspends charging
module li_charger_control_regs #(
   parameter int TICK_CYCLES = chg_regs_pkg::TICK_CYCLES,
   parameter int TICKS_60 = chg_regs_pkg::TICKS_60,
   parameter int TICKS_90 = chg_regs_pkg::TICKS_90,
   parameter int TICKS_120 = chg_regs_pkg::TICKS_120
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_rd_data,
   input wire logic i_sink_over_window,
   input wire logic i_source_over_window,
   input wire logic i_pin_high,
   input wire logic i_vin_above_bat,
   input wire logic i_vin_above_uvlo,
   input wire logic i_over_temp,
   input wire logic i_battery_missing,
   input wire logic i_bat_above_precond,
   input wire logic i_at_termination,
   input wire logic i_end_of_charge,
   input wire logic i_below_restart,
   output logic o_charge_enable,
   output logic [1:0] o_current_mode,
   output logic [3:0] o_fast_charge_level_a,
   output logic [2:0] o_fast_charge_level_b,
   output logic o_linear_supply_mode,
   output logic [2:0] o_state
);
   // Refused at elaboration: a zero timeout count would expire as soon as a charge cycle starts
   if (TICK_CYCLES < 1 || TICKS_60 < 1 || TICKS_90 < 1 || TICKS_120 < 1) begin : g_bad_counts
      $error("Timer counts must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable control fields, status flags and charge state
   logic [3:0] level_a_reg;
   logic [2:0] level_b_reg;
   logic linear_mode_reg;
   logic [1:0] timer_select_reg;
   logic suspend_reg;
   logic usb_select_reg;
   logic exact_reg;
   logic timer_fault_reg;
   logic supply_good_reg;
   logic healthy_reg;
   logic done_reg;
   chg_regs_pkg::charge_state_t state_reg;
   chg_regs_pkg::charge_state_t state_next;
   chg_regs_pkg::level_t level;

   charge_level_decode u_level (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sink_over_window(i_sink_over_window),
      .i_source_over_window(i_source_over_window),
      .i_pin_high(i_pin_high),
      .o_level(level)
   );

   // Only writable fields are stored here; host writes never reach read-only positions
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         level_a_reg <= chg_regs_pkg::RST_LEVEL_A;
         level_b_reg <= chg_regs_pkg::RST_LEVEL_B;
         linear_mode_reg <= chg_regs_pkg::RST_LINEAR_MODE;
         timer_select_reg <= chg_regs_pkg::RST_TIMER_SELECT;
         suspend_reg <= chg_regs_pkg::RST_SUSPEND;
         usb_select_reg <= chg_regs_pkg::RST_USB_SELECT;
         exact_reg <= chg_regs_pkg::RST_EXACT;
      end else if (i_wr_en) begin
         case (i_addr)
            chg_regs_pkg::ADDR_CURRENT_PRIMARY: begin
               level_a_reg <= i_wr_data[chg_regs_pkg::LEVEL_A_LSB +: 4]; // [R02]
            end
            chg_regs_pkg::ADDR_STATUS_TIMEOUT: begin
               timer_select_reg <= i_wr_data[chg_regs_pkg::TIMER_SELECT_LSB +: 2]; // [R02]
            end
            chg_regs_pkg::ADDR_MODE_CURRENT_ALT: begin
               linear_mode_reg <= i_wr_data[chg_regs_pkg::LINEAR_MODE_BIT];
               level_b_reg <= i_wr_data[chg_regs_pkg::LEVEL_B_LSB +: 3];
            end
            chg_regs_pkg::ADDR_CONTROL_FLAGS: begin
               suspend_reg <= i_wr_data[chg_regs_pkg::SUSPEND_BIT]; // [R11]
               usb_select_reg <= i_wr_data[chg_regs_pkg::USB_SELECT_BIT];
               exact_reg <= i_wr_data[chg_regs_pkg::EXACT_BIT]; // [R01]
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timeout tick divider and charge timer
   logic [$clog2(TICK_CYCLES + 1)-1:0] div_reg;
   logic tick;
   logic [31:0] timer_reg;
   logic [31:0] limit;
   logic active;

   assign tick = (div_reg == '0);
   assign active = (state_reg == chg_regs_pkg::ST_PRECONDITION) ||
                   (state_reg == chg_regs_pkg::ST_FAST_CHARGE) ||
                   (state_reg == chg_regs_pkg::ST_TOP_OFF); // [R06]

   always_comb begin
      case (timer_select_reg) // [R08]
         chg_regs_pkg::TIMER_60: limit = 32'(TICKS_60);
         chg_regs_pkg::TIMER_90: limit = 32'(TICKS_90);
         chg_regs_pkg::TIMER_120: limit = 32'(TICKS_120);
         default: limit = '1;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_reg <= '0;
      end else if (tick) begin
         div_reg <= ($clog2(TICK_CYCLES + 1))'(TICK_CYCLES - 1);
      end else begin
         div_reg <= div_reg - 1'b1;
      end
   end

   logic expired;
   assign expired = (timer_select_reg != chg_regs_pkg::TIMER_NONE) && (timer_reg >= limit);

   // Timer runs only while a charge cycle is active and restarts per cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         timer_reg <= '0;
      end else if (!active) begin
         timer_reg <= '0;
      end else if (tick && !expired) begin
         timer_reg <= timer_reg + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Charge state controller
   logic supply_ok;
   logic blocked;
   assign supply_ok = i_vin_above_bat && i_vin_above_uvlo;
   // Thermal and battery faults also hold off a new cycle and stop a running one
   assign blocked = (level == chg_regs_pkg::LEVEL_FLOAT) || suspend_reg || // [R04] [R11]
                    i_over_temp || i_battery_missing; // [R09]

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         chg_regs_pkg::ST_SLEEP: begin
            if (supply_ok) begin
               state_next = blocked ? chg_regs_pkg::ST_SUSPEND
                                    : chg_regs_pkg::ST_PRECONDITION; // [R09]
            end
         end
         chg_regs_pkg::ST_SUSPEND: begin
            if (!blocked && !timer_fault_reg) begin
               state_next = chg_regs_pkg::ST_PRECONDITION; // [R09]
            end
         end
         chg_regs_pkg::ST_TIMEOUT_FAULT: begin
            state_next = chg_regs_pkg::ST_TIMEOUT_FAULT; // [R08]
         end
         chg_regs_pkg::ST_PRECONDITION: begin
            if (expired) begin
               state_next = chg_regs_pkg::ST_TIMEOUT_FAULT; // [R08]
            end else if (i_bat_above_precond) begin
               state_next = chg_regs_pkg::ST_FAST_CHARGE;
            end
         end
         chg_regs_pkg::ST_FAST_CHARGE: begin
            if (expired) begin
               state_next = chg_regs_pkg::ST_TIMEOUT_FAULT; // [R08]
            end else if (i_at_termination) begin
               state_next = chg_regs_pkg::ST_TOP_OFF;
            end
         end
         chg_regs_pkg::ST_TOP_OFF: begin
            if (expired) begin
               state_next = chg_regs_pkg::ST_TIMEOUT_FAULT; // [R08]
            end else if (i_end_of_charge) begin
               state_next = chg_regs_pkg::ST_SUSPEND;
            end
         end
         default: state_next = chg_regs_pkg::ST_SLEEP;
      endcase
      // Done charge waits in suspend until the battery sags 200 mV
      if (state_reg == chg_regs_pkg::ST_SUSPEND && !i_below_restart && done_reg) begin
         state_next = chg_regs_pkg::ST_SUSPEND; // [R07]
      end
      // Losing input power or a blocking cause overrides any charging state
      if (!supply_ok) begin
         state_next = chg_regs_pkg::ST_SLEEP;
      end else if (blocked && active) begin
         state_next = chg_regs_pkg::ST_SUSPEND; // [R04] [R11]
      end
   end

   // Set after end-of-charge; cleared once the restart threshold is crossed
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         done_reg <= 1'b0;
      end else if (state_reg == chg_regs_pkg::ST_TOP_OFF && i_end_of_charge) begin
         done_reg <= 1'b1;
      end else if (i_below_restart || !supply_ok) begin
         done_reg <= 1'b0; // [R07]
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= chg_regs_pkg::ST_SLEEP;
      end else begin
         state_reg <= state_next; // [R06]
      end
   end

   // Fault latched until input power is removed
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         timer_fault_reg <= 1'b0;
      end else if (active && expired) begin
         timer_fault_reg <= 1'b1; // [R08]
      end else if (!supply_ok) begin
         timer_fault_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         supply_good_reg <= 1'b0;
         healthy_reg <= 1'b0;
      end else begin
         supply_good_reg <= supply_ok; // [R03]
         healthy_reg <= supply_ok && !timer_fault_reg && !i_over_temp &&
                        !i_battery_missing; // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and read-back
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_charge_enable <= 1'b0;
         o_current_mode <= 2'h0;
         o_fast_charge_level_a <= chg_regs_pkg::RST_LEVEL_A;
         o_fast_charge_level_b <= chg_regs_pkg::RST_LEVEL_B;
         o_linear_supply_mode <= chg_regs_pkg::RST_LINEAR_MODE;
         o_state <= 3'h0;
      end else begin
         o_charge_enable <= active;
         // Mode 0: 90 mA level, 1: 450 mA level, 2: programmed level
         o_current_mode <= (level_a_reg != 4'h0) ? 2'h2 :
                           (level == chg_regs_pkg::LEVEL_HIGH) ? 2'h1 : 2'h0; // [R05]
         o_fast_charge_level_a <= level_a_reg;
         o_fast_charge_level_b <= level_b_reg;
         o_linear_supply_mode <= linear_mode_reg;
         o_state <= state_reg;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= 8'h00;
      end else begin
         case (i_addr)
            chg_regs_pkg::ADDR_CURRENT_PRIMARY: o_rd_data <= {level_a_reg, 4'h0};
            chg_regs_pkg::ADDR_STATUS_TIMEOUT: o_rd_data <= {timer_select_reg, 1'b0,
               i_battery_missing, timer_fault_reg, i_over_temp, active,
               supply_good_reg}; // [R03]
            chg_regs_pkg::ADDR_MODE_CURRENT_ALT: o_rd_data <= {linear_mode_reg, level_b_reg,
               4'h0};
            chg_regs_pkg::ADDR_CONTROL_FLAGS: o_rd_data <= {4'h0, exact_reg, usb_select_reg,
               healthy_reg, suspend_reg}; // [R10]
            default: o_rd_data <= 8'h00;
         endcase
      end
   end
endmodule // li_charger_control_regs

// ===== tb_top.sv
// Testbench: registers, level pin, states and timeout of the charger block
`timescale 1ns/1ps
module tb_top;
   localparam int TC = 2;
   localparam int T60 = 10;
   localparam int T90 = 15;
   localparam int T120 = 20;
   localparam logic [2:0] S_SLP = chg_regs_pkg::ST_SLEEP;
   localparam logic [2:0] S_SUS = chg_regs_pkg::ST_SUSPEND;
   localparam logic [2:0] S_PRE = chg_regs_pkg::ST_PRECONDITION;
   localparam logic [2:0] S_FAST = chg_regs_pkg::ST_FAST_CHARGE;
   localparam logic [2:0] S_TOP = chg_regs_pkg::ST_TOP_OFF;
   localparam logic [2:0] S_FLT = chg_regs_pkg::ST_TIMEOUT_FAULT;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_wr_en;
   logic [7:0] i_addr, i_wr_data, o_rd_data;
   logic i_sink_over_window = 1'b0, i_source_over_window = 1'b0, i_pin_high = 1'b0;
   logic i_vin_above_bat = 1'b1, i_vin_above_uvlo = 1'b1, i_over_temp = 1'b0;
   logic i_battery_missing = 1'b0, i_bat_above_precond = 1'b1, i_at_termination = 1'b0;
   logic i_end_of_charge = 1'b0, i_below_restart = 1'b0;
   logic o_charge_enable, o_linear_supply_mode;
   logic [1:0] o_current_mode;
   logic [3:0] o_fast_charge_level_a;
   logic [2:0] o_fast_charge_level_b, o_state;
   int checked = 0;
   int miscompares = 0;
   always #12.5 i_clk = ~i_clk;
   // Short tick and timeout counts keep the timer runs brief
   li_charger_control_regs #(.TICK_CYCLES(TC), .TICKS_60(T60), .TICKS_90(T90),
      .TICKS_120(T120)) dut (.i_clk, .i_rst, .i_wr_en, .i_addr, .i_wr_data, .o_rd_data,
      .i_sink_over_window, .i_source_over_window, .i_pin_high, .i_vin_above_bat,
      .i_vin_above_uvlo, .i_over_temp, .i_battery_missing, .i_bat_above_precond,
      .i_at_termination, .i_end_of_charge, .i_below_restart, .o_charge_enable,
      .o_current_mode, .o_fast_charge_level_a, .o_fast_charge_level_b,
      .o_linear_supply_mode, .o_state);
   chg_host_model host (.i_clk, .i_rd_data(o_rd_data), .o_wr_en(i_wr_en),
      .o_addr(i_addr), .o_wr_data(i_wr_data));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      chk(v, exp);
   endtask
   task automatic wst(input logic [2:0] e);
      int n;
      n = 0;
      while (o_state !== e && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      chk({5'h0, o_state}, {5'h0, e});
   endtask
   task automatic pin(input logic snk, input logic src, input logic hi);
      @(posedge i_clk);
      i_sink_over_window <= snk;
      i_source_over_window <= src;
      i_pin_high <= hi;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      wst(S_SUS);
      rdchk(8'h09, 8'h81);
      rdchk(8'h08, 8'h00);
      rdchk(8'h0a, 8'h00);
      rdchk(8'h0b, 8'h02);
      host.wr(8'h09, 8'hc0);
   endtask
   task automatic t_level;
      pin(1'b0, 1'b1, 1'b1);
      wst(S_FAST);
      chk({6'h0, o_current_mode}, 8'h01);
      chk({7'h0, o_charge_enable}, 8'h01);
      rdchk(8'h09, 8'hc3);
      pin(1'b1, 1'b0, 1'b0);
      repeat (4) @(negedge i_clk);
      chk({6'h0, o_current_mode}, 8'h00);
      // A low battery is only judged as a new cycle starts
      @(posedge i_clk);
      i_bat_above_precond <= 1'b0;
      pin(1'b0, 1'b0, 1'b0);
      wst(S_SUS);
      pin(1'b1, 1'b0, 1'b0);
      wst(S_PRE);
      @(posedge i_clk);
      i_bat_above_precond <= 1'b1;
      wst(S_FAST);
      pin(1'b0, 1'b0, 1'b0);
      wst(S_SUS);
      pin(1'b1, 1'b0, 1'b0);
      wst(S_FAST);
   endtask
   task automatic t_regs;
      host.wr(8'h08, 8'hff);
      rdchk(8'h08, 8'hf0);
      chk({4'h0, o_fast_charge_level_a}, 8'h0f);
      chk({6'h0, o_current_mode}, 8'h02);
      host.wr(8'h0a, 8'hff);
      rdchk(8'h0a, 8'hf0);
      chk({4'h0, o_linear_supply_mode, o_fast_charge_level_b}, 8'h0f);
      host.wr(8'h09, 8'hff);
      rdchk(8'h09, 8'hc3);
      host.wr(8'h0c, 8'h55);
      rdchk(8'h0c, 8'h00);
      host.wr(8'h08, 8'h00);
      host.wr(8'h0a, 8'h00);
   endtask
   task automatic t_suspend;
      host.wr(8'h0b, 8'h0f);
      rdchk(8'h0b, 8'h07);
      wst(S_SUS);
      host.wr(8'h0b, 8'h00);
      wst(S_FAST);
      rdchk(8'h0b, 8'h02);
   endtask
   task automatic t_restart;
      @(posedge i_clk);
      i_at_termination <= 1'b1;
      wst(S_TOP);
      @(posedge i_clk);
      i_end_of_charge <= 1'b1;
      wst(S_SUS);
      @(posedge i_clk);
      i_at_termination <= 1'b0;
      i_end_of_charge <= 1'b0;
      repeat (10) @(negedge i_clk);
      chk({5'h0, o_state}, {5'h0, S_SUS});
      @(posedge i_clk);
      i_below_restart <= 1'b1;
      wst(S_FAST);
      @(posedge i_clk);
      i_below_restart <= 1'b0;
   endtask
   task automatic t_fault;
      logic [7:0] v;
      @(posedge i_clk);
      i_over_temp <= 1'b1;
      i_battery_missing <= 1'b1;
      host.rd(8'h09, v);
      chk(v & 8'h1d, 8'h15);
      host.rd(8'h0b, v);
      chk(v & 8'h02, 8'h00);
      chk({7'h0, o_charge_enable}, 8'h00);
      @(posedge i_clk);
      i_over_temp <= 1'b0;
      i_battery_missing <= 1'b0;
   endtask
   task automatic t_timeout;
      int lim [4];
      int n;
      lim = '{T60 * TC, T90 * TC, T120 * TC, 60};
      for (int k = 0; k < 4; k++) begin
         // Losing the supply is the only way out of a timeout fault
         @(posedge i_clk);
         i_vin_above_uvlo <= 1'b0;
         wst(S_SLP);
         if (k == 0) begin
            rdchk(8'h09, 8'hc0);
            rdchk(8'h0b, 8'h00);
         end
         host.wr(8'h09, {2'(k), 6'h00});
         @(posedge i_clk);
         i_vin_above_uvlo <= 1'b1;
         n = 0;
         while (o_state !== S_FLT && n < lim[k] + 12) begin
            @(negedge i_clk);
            n++;
         end
         if (k < 3) begin
            chk(8'((n >= lim[k]) && (n <= lim[k] + 10)), 8'h01);
         end else begin
            chk({5'h0, o_state}, {5'h0, S_FAST});
         end
         if (k == 0) begin
            rdchk(8'h09, 8'h09);
            rdchk(8'h0b, 8'h00);
         end
      end
   endtask
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset;
      t_level;
      t_regs;
      t_suspend;
      t_restart;
      t_fault;
      t_timeout;
      test_done;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      test_done;
   end
endmodule // tb_top
bind li_charger_control_regs chg_regs_asserts chk_i (.i_clk, .i_rst, .i_wr_en, .i_addr,
   .i_wr_data, .o_rd_data, .i_sink_over_window, .i_source_over_window, .i_pin_high,
   .i_vin_above_bat, .i_vin_above_uvlo, .o_charge_enable, .o_current_mode,
   .o_fast_charge_level_a, .o_state);
